/* common/dtc_pkg.sv */
// constants for the dynamic fan-start-temperature control register bank
package dtc_pkg;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_OPPT_REMOTE1 = 8'h33;
  localparam logic [7:0] OFS_OPPT_LOCAL   = 8'h34;
  localparam logic [7:0] OFS_OPPT_REMOTE2 = 8'h35;
  localparam logic [7:0] OFS_CTRL_ONE     = 8'h36;
  localparam logic [7:0] OFS_CYCLE_CODES  = 8'h37;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] RST_CTRL_ONE     = 8'h00;
  localparam logic [7:0] RST_CYCLE_CODES  = 8'h00;
  localparam logic [7:0] RST_OPPT         = 8'h64;
  // ----------------------------------------
  // field positions, control register one
  // ----------------------------------------
  localparam int BIT_R2_CODE_MSB    = 0;
  localparam int BIT_RESERVED       = 1;
  localparam int BIT_R1_CAPTURE     = 2;
  localparam int BIT_LOCAL_CAPTURE  = 3;
  localparam int BIT_R2_CAPTURE     = 4;
  localparam int BIT_R1_DYNAMIC     = 5;
  localparam int BIT_LOCAL_DYNAMIC  = 6;
  localparam int BIT_R2_DYNAMIC     = 7;
  // ----------------------------------------
  // field positions, cycle code register
  // ----------------------------------------
  localparam int POS_R1_CODE    = 0;
  localparam int POS_LOCAL_CODE = 3;
  localparam int POS_R2_CODE    = 6;
  // ----------------------------------------
  // interval scale, in monitoring cycles
  // ----------------------------------------
  localparam logic [10:0] DECREASE_BASE = 11'h004;
  localparam logic [10:0] INCREASE_BASE = 11'h008;
  localparam int NUM_CHANNELS = 3;
endpackage : dtc_pkg

/* verilog/dtc_interval.sv */
// decode of a three-bit delay code into decrease and increase intervals
`timescale 1ns/1ps
module dtc_interval
  import dtc_pkg::*;
(
  // code in
  input  wire logic [2:0]  delay_code,
  // intervals out, in monitoring cycles
  output wire logic [10:0] decrease_cycles,
  output wire logic [10:0] increase_cycles
);
  // decrease four times two to n
  assign decrease_cycles = DECREASE_BASE << delay_code;
  assign increase_cycles = INCREASE_BASE << delay_code;
endmodule : dtc_interval

/* verilog/dtc_regs.sv */
// register bank for dynamic fan-start-temperature control
`timescale 1ns/1ps
module dtc_regs
  import dtc_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  output logic      [7:0]  reg_rdata,
  // global lock from configuration register
  input  wire logic        lock_bit,
  // thermal throttle pin and monitoring
  input  wire logic        thermal_throttle_in,
  input  wire logic        monitor_cycle_end,
  input  wire logic [7:0]  remote1_temp,
  input  wire logic [7:0]  local_temp,
  input  wire logic [7:0]  remote2_temp,
  // outputs to the adjustment loop
  output logic      [7:0]  remote1_oppt,
  output logic      [7:0]  local_oppt,
  output logic      [7:0]  remote2_oppt,
  output logic             remote1_dynamic_en,
  output logic             local_dynamic_en,
  output logic             remote2_dynamic_en,
  output logic      [2:0]  remote1_delay_code,
  output logic      [2:0]  local_delay_code,
  output logic      [2:0]  remote2_delay_code,
  output logic      [32:0] decrease_cycles,
  output logic      [32:0] increase_cycles
);
  // ----------------------------------------
  // storage
  // ----------------------------------------
  logic [7:0] ctrl_one;
  logic [7:0] cycle_codes;
  logic       lock_held;
  logic       throttle_meta;
  logic       throttle_sync;
  logic       throttle_seen;

  // ----------------------------------------
  // pin synchroniser and lock
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      throttle_meta <= 1'b0;
      throttle_sync <= 1'b0;
    end else begin
      throttle_meta <= thermal_throttle_in;
      throttle_sync <= throttle_meta;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      lock_held <= 1'b0;
    end else if (lock_bit) begin
      lock_held <= 1'b1;
    end
  end

  // ----------------------------------------
  // write decode
  // ----------------------------------------
  // writes blocked once locked
  // lock_bit blocks the write in the cycle it rises, lock_held every cycle after
  wire wr_ok      = reg_wr & ~lock_held & ~lock_bit;
  wire wr_ctrl    = wr_ok & (reg_addr == OFS_CTRL_ONE);
  wire wr_cycles  = wr_ok & (reg_addr == OFS_CYCLE_CODES);
  wire [2:0] wr_oppt;
  assign wr_oppt[0] = wr_ok & (reg_addr == OFS_OPPT_REMOTE1);
  assign wr_oppt[1] = wr_ok & (reg_addr == OFS_OPPT_LOCAL);
  assign wr_oppt[2] = wr_ok & (reg_addr == OFS_OPPT_REMOTE2);

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ctrl_one <= RST_CTRL_ONE;
    end else if (wr_ctrl) begin
      ctrl_one <= reg_wdata & ~(8'h01 << BIT_RESERVED);
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cycle_codes <= RST_CYCLE_CODES;
    end else if (wr_cycles) begin
      cycle_codes <= reg_wdata;
    end
  end

  // ----------------------------------------
  // throttle capture
  // ----------------------------------------
  // remember throttle within monitoring cycle
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      throttle_seen <= 1'b0;
    end else if (monitor_cycle_end) begin
      throttle_seen <= 1'b0;
    end else if (throttle_sync) begin
      throttle_seen <= 1'b1;
    end
  end

  // a throttle rising in the last two clocks of a monitoring cycle reaches the
  // synchroniser late and so counts toward the next cycle
  wire       seen_now = throttle_seen | throttle_sync;
  wire [2:0] cap_en;
  wire [7:0] cur_temp [NUM_CHANNELS];
  logic [7:0] oppt [NUM_CHANNELS];
  assign cap_en[0] = ctrl_one[BIT_R1_CAPTURE];
  assign cap_en[1] = ctrl_one[BIT_LOCAL_CAPTURE];
  assign cap_en[2] = ctrl_one[BIT_R2_CAPTURE];
  assign cur_temp[0] = remote1_temp;
  assign cur_temp[1] = local_temp;
  assign cur_temp[2] = remote2_temp;

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CHANNELS; ch++) begin : g_oppt
      // capture ignores the lock: only software writes are frozen
      // capture beats a same-cycle write; likewise local
      always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
          oppt[ch] <= RST_OPPT;
        end else if (monitor_cycle_end && seen_now && cap_en[ch]) begin
          oppt[ch] <= cur_temp[ch];
        end else if (wr_oppt[ch]) begin
          oppt[ch] <= reg_wdata;
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // field outputs
  // ----------------------------------------
  assign remote1_oppt = oppt[0];
  assign local_oppt   = oppt[1];
  assign remote2_oppt = oppt[2];
  // enables and codes are plain register bits, valid one clock after the write
  // remote-1 enable
  assign remote1_dynamic_en = ctrl_one[BIT_R1_DYNAMIC];
  assign local_dynamic_en   = ctrl_one[BIT_LOCAL_DYNAMIC];
  // remote-2 enable; loop holds start temperature when low
  assign remote2_dynamic_en = ctrl_one[BIT_R2_DYNAMIC];
  assign remote1_delay_code = cycle_codes[POS_R1_CODE +: 3];
  assign local_delay_code   = cycle_codes[POS_LOCAL_CODE +: 3];
  assign remote2_delay_code = {ctrl_one[BIT_R2_CODE_MSB], cycle_codes[POS_R2_CODE +: 2]};

  // one decoder per channel, packed 11 bits each: remote-1, local, remote-2
  wire [2:0] codes [NUM_CHANNELS];
  assign codes[0] = remote1_delay_code;
  assign codes[1] = local_delay_code;
  assign codes[2] = remote2_delay_code;
  generate
    for (ch = 0; ch < NUM_CHANNELS; ch++) begin : g_int
      dtc_interval u_int (
        .delay_code      (codes[ch]),
        .decrease_cycles (decrease_cycles[ch*11 +: 11]),
        .increase_cycles (increase_cycles[ch*11 +: 11])
      );
    end
  endgenerate

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  wire rd_ctrl   = (reg_addr == OFS_CTRL_ONE);
  wire rd_cycles = (reg_addr == OFS_CYCLE_CODES);
  wire rd_r1     = (reg_addr == OFS_OPPT_REMOTE1);
  wire rd_local  = (reg_addr == OFS_OPPT_LOCAL);
  wire rd_r2     = (reg_addr == OFS_OPPT_REMOTE2);
  // unmapped offsets read zero so a stray read never shows stale data
  always_comb begin
    if (rd_ctrl) begin
      reg_rdata = ctrl_one;
    end else if (rd_cycles) begin
      reg_rdata = cycle_codes;
    end else if (rd_r1) begin
      reg_rdata = oppt[0];
    end else if (rd_local) begin
      reg_rdata = oppt[1];
    end else if (rd_r2) begin
      reg_rdata = oppt[2];
    end else begin
      reg_rdata = 8'h00;
    end
  end
endmodule : dtc_regs

/* sim/dtc_regs_sva.sv */
// checker for the dynamic start-temperature register bank
`timescale 1ns/1ps
module dtc_regs_sva
  import dtc_pkg::*;
(
  input wire logic        mclk, rstn, reg_wr, lock_bit, thermal_throttle_in, monitor_cycle_end,
  input wire logic [7:0]  reg_addr, reg_wdata, reg_rdata, remote1_temp, local_temp, remote2_temp,
  input wire logic [7:0]  remote1_oppt, local_oppt, remote2_oppt,
  input wire logic        remote1_dynamic_en, local_dynamic_en, remote2_dynamic_en,
  input wire logic [2:0]  remote1_delay_code, local_delay_code, remote2_delay_code,
  input wire logic [32:0] decrease_cycles, increase_cycles
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  // lock seen at an earlier edge; the design keeps it until reset
  logic seen;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) seen <= 1'b0;
    else if (lock_bit) seen <= 1'b1;
  end
  AST_CODES: assert property (reg_addr == OFS_CYCLE_CODES |->
    reg_rdata == {remote2_delay_code[1:0], local_delay_code, remote1_delay_code}) else $error("code fields");
  AST_ONE: assert property (reg_addr == OFS_CTRL_ONE |-> !reg_rdata[1] &&
    reg_rdata[0] == remote2_delay_code[2] &&
    reg_rdata[7:5] == {remote2_dynamic_en, local_dynamic_en, remote1_dynamic_en}) else $error("ctrl one");
  AST_DEC: assert property (decrease_cycles == {DECREASE_BASE << remote2_delay_code,
    DECREASE_BASE << local_delay_code, DECREASE_BASE << remote1_delay_code}) else $error("decrease");
  AST_INC: assert property (increase_cycles == {decrease_cycles[31:22], 1'b0,
    decrease_cycles[20:11], 1'b0, decrease_cycles[9:0], 1'b0}) else $error("increase");
  AST_LOCK: assert property (seen |=> $stable({remote2_dynamic_en, local_dynamic_en,
    remote1_dynamic_en, remote1_delay_code, local_delay_code, remote2_delay_code})) else $error("locked");
  AST_OPLOCK: assert property (seen && !monitor_cycle_end |=>
    $stable({remote1_oppt, local_oppt, remote2_oppt})) else $error("oppt locked");
  AST_OPHOLD: assert property (!reg_wr && !monitor_cycle_end |=>
    $stable({remote1_oppt, local_oppt, remote2_oppt})) else $error("oppt moved");
  AST_R2OFF: assert property (monitor_cycle_end && !reg_wr &&
    reg_addr == OFS_CTRL_ONE && !reg_rdata[4] |=> $stable(remote2_oppt)) else $error("remote-2 capture off");
  AST_LOFF: assert property (monitor_cycle_end && !reg_wr &&
    reg_addr == OFS_CTRL_ONE && !reg_rdata[3] |=> $stable(local_oppt)) else $error("local capture off");
  AST_RST: assert property ($rose(rstn) |-> {remote1_delay_code, local_delay_code,
    remote2_delay_code} == 9'h000 && local_oppt == RST_OPPT) else $error("reset value");
  AST_WR: assert property (reg_wr && !lock_bit && !seen && reg_addr == OFS_CYCLE_CODES |=>
    {remote2_delay_code[1:0], local_delay_code, remote1_delay_code} == $past(reg_wdata)) else $error("write");
  COV_LOCKWR: cover property (reg_wr && seen);
  COV_CAPT: cover property (monitor_cycle_end ##1 $changed(local_oppt));
  COV_WR: cover property (reg_wr && reg_addr == OFS_CTRL_ONE);
endmodule : dtc_regs_sva

/* sim/testbench.sv */
// self-checking bench for the dynamic start-temperature register bank
`timescale 1ns/1ps
module testbench;
  import dtc_pkg::*;
  logic        mclk = 1'h0, rstn = 1'h0, reg_wr = 1'h0, lock_bit = 1'h0;
  logic        thermal_throttle_in = 1'h0, monitor_cycle_end = 1'h0;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00;
  logic [7:0]  remote1_temp = 8'h11, local_temp = 8'h22, remote2_temp = 8'h33;
  logic [7:0]  reg_rdata, remote1_oppt, local_oppt, remote2_oppt;
  logic        remote1_dynamic_en, local_dynamic_en, remote2_dynamic_en;
  logic [2:0]  remote1_delay_code, local_delay_code, remote2_delay_code;
  logic [32:0] decrease_cycles, increase_cycles;
  logic [10:0] e;
  int          errors = 0, compares = 0;
  dtc_regs u_dut (
    .mclk                (mclk),
    .rstn                (rstn),
    .reg_addr            (reg_addr),
    .reg_wdata           (reg_wdata),
    .reg_wr              (reg_wr),
    .reg_rdata           (reg_rdata),
    .lock_bit            (lock_bit),
    .thermal_throttle_in (thermal_throttle_in),
    .monitor_cycle_end   (monitor_cycle_end),
    .remote1_temp        (remote1_temp),
    .local_temp          (local_temp),
    .remote2_temp        (remote2_temp),
    .remote1_oppt        (remote1_oppt),
    .local_oppt          (local_oppt),
    .remote2_oppt        (remote2_oppt),
    .remote1_dynamic_en  (remote1_dynamic_en),
    .local_dynamic_en    (local_dynamic_en),
    .remote2_dynamic_en  (remote2_dynamic_en),
    .remote1_delay_code  (remote1_delay_code),
    .local_delay_code    (local_delay_code),
    .remote2_delay_code  (remote2_delay_code),
    .decrease_cycles     (decrease_cycles),
    .increase_cycles     (increase_cycles)
  );
  always #25 mclk = ~mclk;
  task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
    end
  endtask : cmp
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    @(posedge mclk);
    reg_addr <= a;
    @(negedge mclk);
    cmp(reg_rdata, x);
  endtask : rd
  // one-clock throttle pulse: the synchroniser drains before the cycle end,
  // so nothing spills into the next monitoring cycle
  task automatic cycle_end(input logic t);
    @(posedge mclk);
    thermal_throttle_in <= t;
    @(posedge mclk);
    thermal_throttle_in <= 1'b0;
    repeat (3) @(posedge mclk);
    monitor_cycle_end <= 1'b1;
    @(posedge mclk);
    monitor_cycle_end <= 1'b0;
  endtask : cycle_end
  task automatic finish_test;
    if (errors == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test
  initial begin
    #100us;
    errors++;
    finish_test();
  end
  initial begin
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    rd(OFS_CYCLE_CODES, 8'h00);
    rd(OFS_OPPT_REMOTE2, RST_OPPT);
    rd(8'h40, 8'h00);
    wr(OFS_CTRL_ONE, 8'hFF);
    rd(OFS_CTRL_ONE, 8'hFD);
    cmp({remote2_dynamic_en, local_dynamic_en, remote1_dynamic_en}, 3'h7);
    wr(OFS_CTRL_ONE, 8'h00);
    rd(OFS_CTRL_ONE, 8'h00);
    cmp({remote2_dynamic_en, local_dynamic_en, remote1_dynamic_en}, 3'h0);
    for (int n = 0; n < 8; n++) begin
      e = 11'h004 << n;
      wr(OFS_CYCLE_CODES, {n[1:0], n[2:0], n[2:0]});
      wr(OFS_CTRL_ONE, {7'h00, n[2]});
      @(negedge mclk);
      cmp(remote2_delay_code, n[2:0]);
      cmp({local_delay_code, remote1_delay_code}, {n[2:0], n[2:0]});
      cmp(decrease_cycles, {e, e, e});
      cmp(increase_cycles, {e << 1, e << 1, e << 1});
    end
    wr(OFS_OPPT_LOCAL, 8'h50);
    wr(OFS_OPPT_REMOTE2, 8'h50);
    wr(OFS_CTRL_ONE, 8'h00);
    cycle_end(1'b1);
    rd(OFS_OPPT_LOCAL, 8'h50);
    rd(OFS_OPPT_REMOTE2, 8'h50);
    wr(OFS_CTRL_ONE, 8'h1C);
    cycle_end(1'b1);
    rd(OFS_OPPT_LOCAL, 8'h22);
    rd(OFS_OPPT_REMOTE2, 8'h33);
    rd(OFS_OPPT_REMOTE1, 8'h11);
    cmp({remote1_oppt, local_oppt, remote2_oppt}, {8'h11, 8'h22, 8'h33});
    @(posedge mclk);
    local_temp <= 8'h44;
    cycle_end(1'b0);
    rd(OFS_OPPT_LOCAL, 8'h22);
    @(posedge mclk);
    lock_bit <= 1'b1;
    wr(OFS_CYCLE_CODES, 8'h00);
    lock_bit <= 1'b0;
    wr(OFS_CTRL_ONE, 8'h00);
    wr(OFS_OPPT_LOCAL, 8'h00);
    rd(OFS_CYCLE_CODES, 8'hFF);
    rd(OFS_CTRL_ONE, 8'h1C);
    rd(OFS_OPPT_LOCAL, 8'h22);
    @(posedge mclk);
    rstn <= 1'b0;
    @(posedge mclk);
    rstn <= 1'b1;
    wr(OFS_CYCLE_CODES, 8'h2A);
    rd(OFS_CYCLE_CODES, 8'h2A);
    cmp(local_delay_code, 3'h5);
    finish_test();
  end
endmodule : testbench
bind dtc_regs dtc_regs_sva u_sva (
  .mclk                (mclk),
  .rstn                (rstn),
  .reg_wr              (reg_wr),
  .lock_bit            (lock_bit),
  .thermal_throttle_in (thermal_throttle_in),
  .monitor_cycle_end   (monitor_cycle_end),
  .reg_addr            (reg_addr),
  .reg_wdata           (reg_wdata),
  .reg_rdata           (reg_rdata),
  .remote1_temp        (remote1_temp),
  .local_temp          (local_temp),
  .remote2_temp        (remote2_temp),
  .remote1_oppt        (remote1_oppt),
  .local_oppt          (local_oppt),
  .remote2_oppt        (remote2_oppt),
  .remote1_dynamic_en  (remote1_dynamic_en),
  .local_dynamic_en    (local_dynamic_en),
  .remote2_dynamic_en  (remote2_dynamic_en),
  .remote1_delay_code  (remote1_delay_code),
  .local_delay_code    (local_delay_code),
  .remote2_delay_code  (remote2_delay_code),
  .decrease_cycles     (decrease_cycles),
  .increase_cycles     (increase_cycles)
);
